/* File: core/bic_pkg.sv */
package bic_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [15:0] CTRL_RESET = 16'h3ff3;
  // Bits 14, 3 and 2 always read as zero
  localparam logic [15:0] CTRL_RW_MASK = 16'hbff3;
  localparam int WAIT_SEL_BIT = 15;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ==========================================================
  // Per-area idle fields
  // ==========================================================
  localparam int AREA_COUNT = 8;
  localparam int AREA_W = 3;
  localparam int IDLE_W = 2;
  // Field lsb per area; areas 1 and 7 have no field
  localparam int AREA_FIELD_LSB [AREA_COUNT] = '{0, 0, 4, 6, 8, 10, 12, 0};
  localparam logic [AREA_COUNT-1:0] AREA_HAS_FIELD = 8'h7d;
  localparam logic [IDLE_W-1:0] IDLE_ONE = 2'h1;
  localparam logic [IDLE_W-1:0] IDLE_NONE = 2'h0;
  localparam logic [IDLE_W-1:0] CODE_TWO = 2'h2;
  localparam logic [IDLE_W-1:0] CODE_THREE = 2'h3;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    SEQ_READY = 3'h1,
    SEQ_IDLE = 3'h2,
    SEQ_BUSY = 3'h4
  } bic_seq_t;

  typedef struct packed {
    logic [AREA_W-1:0] area;
    logic write;
  } bic_access_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic waitreq;
    logic [31:0] rdata;
    bic_seq_t seq;
    logic [IDLE_W-1:0] idle_cnt;
    bic_access_t last;
    logic last_valid;
    logic grant;
    logic idle;
    logic bclk;
    logic wait_s1;
    logic wait_s2;
    logic wait_smp;
    logic mrst_s1;
    logic mrst_s2;
  } bic_state_t;

endpackage

/* File: core/bic_top.sv */
// Overview of operation
// - Control register is 16 bits, read/write, power-on reset value 0x3ff3.
// - Manual reset and standby leave the control register untouched.
// - Insert programmed idles on area change or read followed by write.
// - Idle field 00 and 01 give one idle, 10 two, 11 three.
// - Area 6 idle field sits in bits 13:12, resets to ones.
// - Area 5 idle field sits in bits 11:10, resets to ones.
// - Area 4 idle field sits in bits 9:8, resets to ones.
// - Area 3 idle field sits in bits 7:6, resets to ones.
// - Area 2 idle field sits in bits 5:4, resets to ones.
// - Area 0 idle field sits in bits 1:0, resets to ones.
// - Wait select bit 15 set samples wait on bus clock falling edge.
// - Bits 14, 3, 2 read zero; software writes only zero there.
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns

module bic_top (
  // Clock and power-on reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Access requests from the bus state controller
  input wire logic acc_req_in,
  input wire logic [bic_pkg::AREA_W-1:0] acc_area_in,
  input wire logic acc_write_in,
  input wire logic acc_done_in,
  input wire logic standby_in,
  output logic acc_grant_out,
  output logic bus_idle_out,
  // Pins
  input wire logic manual_reset_n_in,
  input wire logic ext_wait_in,
  output logic bus_clock_output_out,
  output logic wait_sampled_out
);

  // ==========================================================
  // State
  // ==========================================================
  bic_pkg::bic_state_t state_reg;
  bic_pkg::bic_state_t state_next;

  logic [bic_pkg::IDLE_W-1:0] area_idles [bic_pkg::AREA_COUNT];
  bic_pkg::bic_access_t req_acc;
  logic need_idle;
  logic [bic_pkg::IDLE_W-1:0] idle_amount;
  logic bus_req;
  logic bus_hit;
  logic [15:0] be_mask;
  logic [15:0] wr_value;
  logic manual_reset;
  logic bclk_fall;
  logic bclk_rise;

  // ==========================================================
  // Per-area idle decode
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < bic_pkg::AREA_COUNT; gi = gi + 1) begin : g_area
      logic [bic_pkg::IDLE_W-1:0] code;
      assign code = state_reg.ctrl[bic_pkg::AREA_FIELD_LSB[gi] +: bic_pkg::IDLE_W];
      always_comb begin
        // Areas without a field add no idles
        if (!bic_pkg::AREA_HAS_FIELD[gi]) begin
          area_idles[gi] = bic_pkg::IDLE_NONE;
        end else if (code == bic_pkg::CODE_THREE) begin
          area_idles[gi] = bic_pkg::CODE_THREE;
        end else if (code == bic_pkg::CODE_TWO) begin
          area_idles[gi] = bic_pkg::CODE_TWO;
        end else begin
          area_idles[gi] = bic_pkg::IDLE_ONE;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Idle need for the pending access
  // ==========================================================
  always_comb begin
    req_acc.area = acc_area_in;
    req_acc.write = acc_write_in;
    need_idle = 1'b0;
    idle_amount = area_idles[state_reg.last.area];
    if (state_reg.last_valid) begin
      if (req_acc.area != state_reg.last.area) begin
        need_idle = 1'b1;
      end else if (!state_reg.last.write && req_acc.write) begin
        need_idle = 1'b1;
      end else begin
        need_idle = 1'b0;
      end
    end
    if (idle_amount == bic_pkg::IDLE_NONE) begin
      need_idle = 1'b0;
    end
  end

  // ==========================================================
  // Register bus decode
  // ==========================================================
  always_comb begin
    bus_req = avs_read_in | avs_write_in;
    bus_hit = avs_address_in == bic_pkg::CTRL_OFFSET;
    be_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wr_value = (state_reg.ctrl & ~be_mask) | (avs_writedata_in[15:0] & be_mask);
  end

  assign manual_reset = !state_reg.mrst_s2;
  assign bclk_fall = state_reg.bclk;
  assign bclk_rise = !state_reg.bclk;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    state_next = state_reg;
    state_next.grant = 1'b0;

    // Pin synchronisers
    state_next.wait_s1 = ext_wait_in;
    state_next.wait_s2 = state_reg.wait_s1;
    state_next.mrst_s1 = manual_reset_n_in;
    state_next.mrst_s2 = state_reg.mrst_s1;

    // Bus clock output runs at half the core clock
    state_next.bclk = !state_reg.bclk;
    if (state_reg.ctrl[bic_pkg::WAIT_SEL_BIT]) begin
      if (bclk_fall) begin
        state_next.wait_smp = state_reg.wait_s2;
      end
    end else if (bclk_rise) begin
      state_next.wait_smp = state_reg.wait_s2;
    end

    // One wait cycle on every slave access, then complete
    state_next.waitreq = !(bus_req && state_reg.waitreq);
    if (bus_req && state_reg.waitreq) begin
      state_next.rdata = bic_pkg::UNMAPPED_READ;
      if (avs_read_in && bus_hit) begin
        state_next.rdata = {16'h0000, state_reg.ctrl & bic_pkg::CTRL_RW_MASK};
      end
    end
    if (avs_write_in && !state_reg.waitreq && bus_hit) begin
      state_next.ctrl = wr_value & bic_pkg::CTRL_RW_MASK;
    end

    // Access sequencer; manual reset clears it, never the register
    case (state_reg.seq)
      bic_pkg::SEQ_READY: begin
        if (acc_req_in && !standby_in) begin
          if (need_idle) begin
            state_next.seq = bic_pkg::SEQ_IDLE;
            state_next.idle = 1'b1;
            state_next.idle_cnt = idle_amount - 2'h1;
          end else begin
            state_next.seq = bic_pkg::SEQ_BUSY;
            state_next.grant = 1'b1;
            state_next.last = req_acc;
            state_next.last_valid = 1'b1;
          end
        end
      end
      bic_pkg::SEQ_IDLE: begin
        if (state_reg.idle_cnt == bic_pkg::IDLE_NONE) begin
          state_next.seq = bic_pkg::SEQ_BUSY;
          state_next.idle = 1'b0;
          state_next.grant = 1'b1;
          state_next.last = req_acc;
          state_next.last_valid = 1'b1;
        end else begin
          state_next.idle_cnt = state_reg.idle_cnt - 2'h1;
        end
      end
      bic_pkg::SEQ_BUSY: begin
        if (acc_done_in) begin
          state_next.seq = bic_pkg::SEQ_READY;
        end
      end
      default: begin
        state_next.seq = bic_pkg::SEQ_READY;
      end
    endcase

    if (manual_reset) begin
      state_next.seq = bic_pkg::SEQ_READY;
      state_next.idle = 1'b0;
      state_next.grant = 1'b0;
      state_next.idle_cnt = bic_pkg::IDLE_NONE;
      state_next.last_valid = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg.ctrl <= bic_pkg::CTRL_RESET;
      state_reg.waitreq <= 1'b1;
      state_reg.rdata <= bic_pkg::UNMAPPED_READ;
      state_reg.seq <= bic_pkg::SEQ_READY;
      state_reg.idle_cnt <= bic_pkg::IDLE_NONE;
      state_reg.last <= '0;
      state_reg.last_valid <= 1'b0;
      state_reg.grant <= 1'b0;
      state_reg.idle <= 1'b0;
      state_reg.bclk <= 1'b0;
      state_reg.wait_s1 <= 1'b0;
      state_reg.wait_s2 <= 1'b0;
      state_reg.wait_smp <= 1'b0;
      state_reg.mrst_s1 <= 1'b1;
      state_reg.mrst_s2 <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign avs_readdata_out = state_reg.rdata;
  assign avs_waitrequest_out = state_reg.waitreq;
  assign acc_grant_out = state_reg.grant;
  assign bus_idle_out = state_reg.idle;
  assign bus_clock_output_out = state_reg.bclk;
  assign wait_sampled_out = state_reg.wait_smp;

endmodule // bic_top

/* File: testbench/bic_bus_model.sv */
`timescale 1ns/1ns
// ========
// Memory model
module bic_bus_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Handshake
  input wire logic grant_in,
  input wire logic [1:0] lat_in,
  output logic done_out
);
  logic busy;
  logic [1:0] cnt;
  // Latency plays fast and slow memories
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy <= 1'b0;
      cnt <= 2'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= busy && cnt == 2'h0;
      if (grant_in) begin
        busy <= 1'b1;
        cnt <= lat_in;
      end else if (busy) begin
        busy <= cnt != 2'h0;
        cnt <= cnt - 2'h1;
      end
    end
  end
endmodule // bic_bus_model

/* File: testbench/bic_top_asserts.sv */
`timescale 1ns/1ns
// ========
// Checker
module bic_top_asserts (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Register bus
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_address_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // Sequencer and bus clock
  input wire logic acc_req_in,
  input wire logic acc_grant_out,
  input wire logic bus_idle_out,
  input wire logic bus_clock_output_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  req_wait_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus request unanswered");
  wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  resv_zero_a: assert property (!avs_waitrequest_out && avs_read_in && avs_address_in == 4'h0 |->
    (avs_readdata_out & 32'hffff_400c) == 32'h0) else $error("reserved bits read nonzero");
  grant_pulse_a: assert property (acc_grant_out |=> !acc_grant_out)
    else $error("grant longer than one cycle");
  idle_grant_a: assert property ($fell(bus_idle_out) |-> acc_grant_out)
    else $error("idle run not followed by grant");
  idle_max_a: assert property (bus_idle_out [*3] |=> !bus_idle_out)
    else $error("more than three idles");
  grant_soon_a: assert property ($rose(acc_req_in) |-> ##[1:4] acc_grant_out)
    else $error("grant late");
  clk_half_a: assert property (bus_clock_output_out |=> !bus_clock_output_out)
    else $error("bus clock not halved");
  clk_low_a: assert property (!bus_clock_output_out |=> bus_clock_output_out)
    else $error("bus clock stuck low");
  cover property (bus_idle_out [*3]);
  cover property ($fell(bus_idle_out));
  cover property (!avs_waitrequest_out && avs_write_in);
endmodule // bic_top_asserts

/* File: testbench/bic_top_tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t %h %h", $time, a, e); end end
// ========
// Bench
module bic_top_tb;
  logic clock_in, nrst_in, rd, wr, req, aw, sb, mrst_n, ew, wrq, gnt, idle, done, ws;
  logic [3:0] adr, be;
  logic [31:0] wd, q;
  logic [2:0] ar;
  logic [1:0] lat;
  logic [15:0] v;
  logic [2:0] al [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  int n_errors, checks, cyc;
  bic_top dut (.clock_in, .nrst_in, .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(q), .avs_waitrequest_out(wrq),
    .acc_req_in(req), .acc_area_in(ar), .acc_write_in(aw), .acc_done_in(done), .standby_in(sb),
    .acc_grant_out(gnt), .bus_idle_out(idle), .manual_reset_n_in(mrst_n), .ext_wait_in(ew),
    .bus_clock_output_out(), .wait_sampled_out(ws));
  bic_bus_model mem (.clock_in, .nrst_in, .grant_in(gnt), .lat_in(lat), .done_out(done));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // Ceiling well above the thousand or so cycles needed
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  task complete_run;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clock_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do @(posedge clock_in); while (wrq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input logic [15:0] e);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    `CHK(q, {16'h0, e})
  endtask
  // Counts idle cycles seen before the grant
  task acc(input logic [2:0] a, input logic w, input int n);
    logic [3:0] c;
    @(posedge clock_in);
    req <= 1'b1;
    ar <= a;
    aw <= w;
    c = 0;
    do begin @(posedge clock_in); c += idle; end while (gnt !== 1'b1);
    req <= 1'b0;
    do @(posedge clock_in); while (done !== 1'b1);
    `CHK(c, n)
  endtask
  task wait_pin(input logic p);
    ew <= p;
    repeat (8) @(posedge clock_in);
    `CHK(ws, p)
  endtask
  initial begin
    {nrst_in, rd, wr, req, aw, sb, ew, lat, adr, wd, ar, n_errors, checks, cyc} = '0;
    be = 4'hf;
    mrst_n = 1'b1;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    rchk(16'h3ff3);
    bus(1'b1, 4'h0, 32'h0000_bff3, 4'hf);
    rchk(16'hbff3);
    wait_pin(1'b1);
    bus(1'b1, 4'h0, 32'h0, 4'h1);
    rchk(16'hbf00);
    bus(1'b1, 4'h4, 32'h0, 4'hf);
    rchk(16'hbf00);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    bus(1'b1, 4'h0, 32'h0, 4'h2);
    wait_pin(1'b0);
    acc(3'h1, 1'b0, 0);
    for (int i = 0; i < 6; i++) for (int c = 0; c < 4; c++) begin
      v = 16'(c) << (2 * al[i]);
      lat <= 2'(c);
      bus(1'b1, 4'h0, {16'h0, v}, 4'hf);
      rchk(v);
      acc(al[i], 1'b0, 0);
      acc(al[i], 1'b0, 0);
      acc(al[i], 1'b1, (c < 2) ? 1 : c);
      acc(3'h1, 1'b0, (c < 2) ? 1 : c);
    end
    bus(1'b1, 4'h0, 32'h9a71, 4'hf);
    acc(3'h6, 1'b0, 0);
    mrst_n <= 1'b0;
    repeat (4) @(posedge clock_in);
    mrst_n <= 1'b1;
    repeat (4) @(posedge clock_in);
    rchk(16'h9a71);
    acc(3'h2, 1'b0, 0);
    sb <= 1'b1;
    repeat (4) @(posedge clock_in);
    sb <= 1'b0;
    rchk(16'h9a71);
    complete_run;
  end
endmodule // bic_top_tb
bind bic_top bic_top_asserts chk (.clock_in, .nrst_in, .avs_read_in, .avs_write_in, .avs_address_in,
  .avs_readdata_out, .avs_waitrequest_out, .acc_req_in, .acc_grant_out, .bus_idle_out, .bus_clock_output_out);
